// ==== src/gdi_i2c_slave.sv ====
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps

// Function
// - serial port works with master clock up to 1 MHz.
// - bytes are eight bits msb first plus a ninth acknowledge clock.
// - start is sda fall with scl high, stop is sda rise; repeated start continues.
// - stop aborts the frame anywhere, unless in the same scl high as start.
// - first byte is seven address bits plus direction bit, 1 read.
// - address bytes E8/E9 with select pin low, EA/EB with pin high.
// - after each good byte hold sda low for the whole ninth clock.
// - pointer loads from six low bits of the byte after write address.
// - two bytes after pointer form the word, each acknowledged.
// - pointer advances after every second written data byte.
// - after writing 0x2E the pointer parks at 0xFF until reloaded.
// - indexed read: write pointer, repeated start, read address, data follows.
// - pointer advances after every second transmitted byte.
// - pointer is kept across stop for later reads.
// - reads above 0x2E return an all-ones word.
// - sda is open drain only, scl is input only.
// - one bit per scl cycle, sda stable while scl high.
// - read data valid at each scl rising edge.
// - port usable 150 ms after supply comes up.
// - word with update code 10 copies all words to dac registers.
// - reserved locations ignore writes but both bytes are acknowledged.
// - common-voltage codes beyond limits are acknowledged then clamped.
module gdi_i2c_slave #(
  parameter int unsigned POWERUP_CYCLES = gdi_pkg::POWERUP_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        ADDR_SELECT_PIN,
  output logic             DAC_UPDATE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  gdi_pkg::gdi_pins_t  pin_s1_ff, pin_s2_ff, pin_d_ff;
  logic                sel_s1_ff, sel_s2_ff;
  gdi_pkg::gdi_state_t state_ff;
  logic [3:0]          bit_cnt_ff;
  logic [7:0]          shift_ff;
  logic [7:0]          tx_ff;
  logic                first_ff;
  logic                rw_ff;
  logic                ptr_loaded_ff;
  logic                half_ff;
  logic [7:0]          ptr_ff;
  logic [7:0]          data_hi_ff;
  logic                mack_ff;
  logic                start_high_ff;
  logic                sda_oe_ff;
  logic                dac_update_ff;
  logic [gdi_pkg::PWR_CNT_W-1:0] pwr_cnt_ff;
  logic                ready_ff;
  logic                ctrl_en_ff;
  logic [5:0]          sel_idx_ff;
  logic [31:0]         wb_dat_ff;
  logic                wb_ack_ff;
  logic [15:0]         regs_ff [gdi_pkg::NUM_REGS];
  logic [15:0]         dac_ff  [gdi_pkg::NUM_REGS];

  logic        live;
  logic        scl_rise, scl_fall, start_det, stop_det, stop_ok;
  logic        byte_done, addr_match, wr_now, upd_now, send_done;
  logic [15:0] wr_word, wr_val, rd_word;
  logic [7:0]  nxt_ptr_step, nxt_tx;
  logic        wb_req;

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  // two flops on every pin; edges are only looked for past the second stage
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_ff <= '1;
      pin_s2_ff <= '1;
      pin_d_ff  <= '1;
      sel_s1_ff <= 1'b0;
      sel_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= '{scl: SCL_IN, sda: SDA_IN};
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
      sel_s1_ff <= ADDR_SELECT_PIN;
      sel_s2_ff <= sel_s1_ff;
    end
  end

  // at 10 MHz a 1 MHz scl high phase still spans about five samples
  assign scl_rise  = pin_s2_ff.scl & ~pin_d_ff.scl;
  assign scl_fall  = ~pin_s2_ff.scl & pin_d_ff.scl;
  assign start_det = pin_s2_ff.scl & pin_d_ff.scl & pin_d_ff.sda & ~pin_s2_ff.sda;
  assign stop_det  = pin_s2_ff.scl & pin_d_ff.scl & ~pin_d_ff.sda & pin_s2_ff.sda;
  assign stop_ok   = stop_det & ~start_high_ff & ~start_det;
  assign live      = ready_ff & ctrl_en_ff;

  // remembers a start inside the current scl high phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      start_high_ff <= 1'b0;
    end else if (start_det) begin
      start_high_ff <= 1'b1;
    end else if (scl_fall) begin
      start_high_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power-up hold-off
  // ----------------------------------------------------------------
  localparam logic [gdi_pkg::PWR_CNT_W-1:0] PWR_LAST = gdi_pkg::PWR_CNT_W'(POWERUP_CYCLES - 1);

  // reset stands in for supply ramp; port stays deaf until the count expires
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_cnt_ff <= '0;
      ready_ff   <= 1'b0;
    end else if (!ready_ff) begin
      pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
      ready_ff   <= (pwr_cnt_ff == PWR_LAST);
    end
  end

  // ----------------------------------------------------------------
  // byte level decode
  // ----------------------------------------------------------------
  assign byte_done  = (state_ff == gdi_pkg::GDI_RECV) & scl_fall & (bit_cnt_ff == gdi_pkg::BYTE_BITS);
  assign addr_match = (shift_ff[7:1] == {gdi_pkg::SLAVE_ADDR_HI, sel_s2_ff});
  assign wr_now     = byte_done & ~first_ff & ptr_loaded_ff & half_ff;
  assign wr_word    = {data_hi_ff, shift_ff};
  assign upd_now    = wr_now & ({wr_word[gdi_pkg::UPD_HI_BIT], wr_word[gdi_pkg::UPD_LO_BIT]}
                                == gdi_pkg::UPDATE_CODE);
  assign send_done  = (state_ff == gdi_pkg::GDI_SEND) & scl_fall & (bit_cnt_ff == gdi_pkg::SEND_LAST);

  // pointer step parks at the top and stays parked
  assign nxt_ptr_step = (ptr_ff >= gdi_pkg::LAST_REG) ? gdi_pkg::PARK_PTR : ptr_ff + 8'h01;
  assign rd_word      = (ptr_ff > gdi_pkg::LAST_REG) ? gdi_pkg::DUMMY_WORD : regs_ff[ptr_ff[5:0]];
  assign nxt_tx       = half_ff ? rd_word[7:0] : rd_word[15:8];

  // clamp of common-voltage codes against the stored limits
  function automatic logic [15:0] clamp_word(input logic [15:0] w, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [9:0] code;
    code = w[gdi_pkg::CODE_MSB:0];
    if (code > hi[gdi_pkg::CODE_MSB:0]) begin
      code = hi[gdi_pkg::CODE_MSB:0];
    end else if (code < lo[gdi_pkg::CODE_MSB:0]) begin
      code = lo[gdi_pkg::CODE_MSB:0];
    end
    return {w[15:gdi_pkg::CODE_MSB+1], code};
  endfunction : clamp_word

  always_comb begin
    wr_val = wr_word;
    if (ptr_ff == gdi_pkg::VCOM1_REG) begin
      wr_val = clamp_word(wr_word, regs_ff[gdi_pkg::VCOM1_MIN[5:0]], regs_ff[gdi_pkg::VCOM1_MAX[5:0]]);
    end else if (ptr_ff == gdi_pkg::VCOM2_REG) begin
      wr_val = clamp_word(wr_word, regs_ff[gdi_pkg::VCOM2_MIN[5:0]], regs_ff[gdi_pkg::VCOM2_MAX[5:0]]);
    end
  end

  // ----------------------------------------------------------------
  // bit level state machine
  // ----------------------------------------------------------------
  // start and stop take priority over any bit activity in the same sample
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff   <= gdi_pkg::GDI_IDLE;
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
      tx_ff      <= '0;
      mack_ff    <= 1'b1;
    end else if (!live) begin
      state_ff   <= gdi_pkg::GDI_IDLE;
    end else if (start_det) begin
      state_ff   <= gdi_pkg::GDI_RECV;
      bit_cnt_ff <= '0;
    end else if (stop_ok) begin
      state_ff   <= gdi_pkg::GDI_IDLE;
    end else begin
      unique case (state_ff)
        gdi_pkg::GDI_IDLE: begin
          bit_cnt_ff <= '0;
        end
        gdi_pkg::GDI_RECV: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], pin_s2_ff.sda};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            // a foreign address leaves us idle until the next start
            state_ff <= (first_ff && !addr_match) ? gdi_pkg::GDI_IDLE : gdi_pkg::GDI_ACK;
          end
        end
        gdi_pkg::GDI_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= '0;
            if (rw_ff) begin
              state_ff <= gdi_pkg::GDI_SEND;
              tx_ff    <= nxt_tx;
            end else begin
              state_ff <= gdi_pkg::GDI_RECV;
            end
          end
        end
        gdi_pkg::GDI_SEND: begin
          if (send_done) begin
            state_ff <= gdi_pkg::GDI_MACK;
          end else if (scl_fall) begin
            tx_ff      <= {tx_ff[6:0], 1'b1};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        gdi_pkg::GDI_MACK: begin
          if (scl_rise) begin
            mack_ff <= pin_s2_ff.sda;
          end else if (scl_fall) begin
            // a not-acknowledge ends our part; the master closes with stop
            bit_cnt_ff <= '0;
            state_ff   <= mack_ff ? gdi_pkg::GDI_IDLE : gdi_pkg::GDI_SEND;
            tx_ff      <= nxt_tx;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame context: direction, pointer, word halves
  // ----------------------------------------------------------------
  // pointer survives stop and repeated start; only a pointer byte reloads it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      first_ff      <= 1'b1;
      rw_ff         <= 1'b0;
      ptr_loaded_ff <= 1'b0;
      half_ff       <= 1'b0;
      ptr_ff        <= '0;
      data_hi_ff    <= '0;
    end else if (start_det) begin
      first_ff      <= 1'b1;
      ptr_loaded_ff <= 1'b0;
      half_ff       <= 1'b0;
    end else if (byte_done && first_ff) begin
      first_ff <= 1'b0;
      rw_ff    <= shift_ff[0];
    end else if (byte_done && !ptr_loaded_ff) begin
      ptr_loaded_ff <= 1'b1;
      // mode bits are expected as zero and only the six low bits count
      ptr_ff        <= {gdi_pkg::PTR_MODE_REG, shift_ff[5:0]};
      half_ff       <= 1'b0;
    end else if (byte_done && !half_ff) begin
      data_hi_ff <= shift_ff;
      half_ff    <= 1'b1;
    end else if (wr_now) begin
      ptr_ff  <= nxt_ptr_step;
      half_ff <= 1'b0;
    end else if (send_done) begin
      half_ff <= ~half_ff;
      if (half_ff) begin
        ptr_ff <= nxt_ptr_step;
      end
    end
  end

  // ----------------------------------------------------------------
  // register words and dac copies
  // ----------------------------------------------------------------
  for (genvar i = 0; i < gdi_pkg::NUM_REGS; i++) begin : g_reg
    localparam logic [7:0]  IDX  = 8'(i);
    localparam logic [15:0] RSTV = (IDX == gdi_pkg::VCOM1_MAX || IDX == gdi_pkg::VCOM2_MAX) ?
                                   gdi_pkg::LIMIT_MAX_RST : gdi_pkg::LIMIT_MIN_RST;
    localparam logic        RSVD = gdi_pkg::gdi_is_rsvd(IDX);
    logic hit;
    assign hit = wr_now & (ptr_ff == IDX) & ~RSVD;

    // first buffer, written from the serial side
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        regs_ff[i] <= RSTV;
      end else if (hit) begin
        regs_ff[i] <= wr_val;
      end
    end

    // second buffer; the word that carries the update code is included
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        dac_ff[i] <= RSTV;
      end else if (upd_now) begin
        dac_ff[i] <= hit ? wr_val : regs_ff[i];
      end
    end
  end

  // one-cycle strobe when the dac copy happens
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dac_update_ff <= 1'b0;
    end else begin
      dac_update_ff <= upd_now;
    end
  end

  // ----------------------------------------------------------------
  // open-drain data line
  // ----------------------------------------------------------------
  // follows the state one cycle late, still well inside scl low
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= live & ((state_ff == gdi_pkg::GDI_ACK) |
                           ((state_ff == gdi_pkg::GDI_SEND) & ~tx_ff[7]));
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = WB_CYC_I & WB_STB_I & ~wb_ack_ff;

  // control writes; unmapped writes are acknowledged and dropped
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_en_ff <= gdi_pkg::CTRL_EN_RST;
      sel_idx_ff <= '0;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == gdi_pkg::WB_CTRL) begin
        ctrl_en_ff <= WB_DAT_I[0];
      end else if (WB_ADR_I == gdi_pkg::WB_SEL) begin
        sel_idx_ff <= WB_DAT_I[5:0];
      end
    end
  end

  // single-cycle answer; reads of unmapped offsets return zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= '0;
    end else begin
      wb_ack_ff <= wb_req;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          gdi_pkg::WB_CTRL:   wb_dat_ff <= {31'h0000_0000, ctrl_en_ff};
          gdi_pkg::WB_STATUS: wb_dat_ff <= {16'h0000, ptr_ff, 6'h00,
                                            state_ff != gdi_pkg::GDI_IDLE, ready_ff};
          gdi_pkg::WB_SEL:    wb_dat_ff <= {26'h000_0000, sel_idx_ff};
          gdi_pkg::WB_DATA:   wb_dat_ff <= (sel_idx_ff < 6'(gdi_pkg::NUM_REGS)) ?
                                           {16'h0000, dac_ff[sel_idx_ff]} : 32'h0000_0000;
          default:            wb_dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SDA_OUT    = 1'b0;
  assign SDA_OE     = sda_oe_ff;
  assign DAC_UPDATE = dac_update_ff;
  assign WB_ACK_O   = wb_ack_ff;
  assign WB_DAT_O   = wb_dat_ff;

endmodule : gdi_i2c_slave

// ==== src/gdi_pkg.sv ====
package gdi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned POWERUP_MS     = 150;
  localparam int unsigned POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MS;
  localparam int unsigned PWR_CNT_W      = 21;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h3A;   // upper six address bits, low bit from the select pin
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] SEND_LAST     = 4'h7;
  localparam logic [1:0] PTR_MODE_REG  = 2'h0;    // pointer_mode_hi/lo value for register access

  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REGS  = 47;
  localparam logic [7:0]  LAST_REG  = 8'h2E;
  localparam logic [7:0]  PARK_PTR  = 8'hFF;
  localparam logic [15:0] DUMMY_WORD = 16'hFFFF;
  localparam logic [7:0]  VCOM1_REG = 8'h12;
  localparam logic [7:0]  VCOM1_MIN = 8'h18;
  localparam logic [7:0]  VCOM1_MAX = 8'h19;
  localparam logic [7:0]  VCOM2_REG = 8'h2C;
  localparam logic [7:0]  VCOM2_MIN = 8'h2D;
  localparam logic [7:0]  VCOM2_MAX = 8'h2E;
  localparam logic [15:0] LIMIT_MIN_RST = 16'h0000;
  localparam logic [15:0] LIMIT_MAX_RST = 16'h03FF;
  localparam logic [1:0]  UPDATE_CODE   = 2'h2;   // update_ctrl_hi = 1, update_ctrl_lo = 0
  localparam int unsigned UPD_HI_BIT    = 15;
  localparam int unsigned UPD_LO_BIT    = 14;
  localparam int unsigned CODE_MSB      = 9;
  localparam logic [7:0]  RSVD_A_LO = 8'h0C;
  localparam logic [7:0]  RSVD_A_HI = 8'h11;
  localparam logic [7:0]  RSVD_B_LO = 8'h13;
  localparam logic [7:0]  RSVD_B_HI = 8'h17;
  localparam logic [7:0]  RSVD_C_LO = 8'h1A;
  localparam logic [7:0]  RSVD_C_HI = 8'h1E;

  // ----------------------------------------------------------------
  // wishbone register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  WB_CTRL   = 4'h0;  // bit0 port enable
  localparam logic [3:0]  WB_STATUS = 4'h4;  // bit0 ready, bit1 busy, bits 15:8 pointer
  localparam logic [3:0]  WB_SEL    = 4'h8;  // dac word index for WB_DATA
  localparam logic [3:0]  WB_DATA   = 4'hC;  // selected dac word, read only
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int unsigned ST_READY_BIT = 0;
  localparam int unsigned ST_BUSY_BIT  = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GDI_IDLE = 3'b000,
    GDI_RECV = 3'b001,
    GDI_ACK  = 3'b011,
    GDI_SEND = 3'b010,
    GDI_MACK = 3'b110
  } gdi_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } gdi_pins_t;

  function automatic logic gdi_is_rsvd(input logic [7:0] a);
    return (a >= RSVD_A_LO && a <= RSVD_A_HI) || (a >= RSVD_B_LO && a <= RSVD_B_HI) ||
           (a >= RSVD_C_LO && a <= RSVD_C_HI);
  endfunction : gdi_is_rsvd

endpackage : gdi_pkg

// ==== tb/gdi_i2c_master_model.sv ====
`timescale 1ns/10ps
module gdi_i2c_master_model (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  // idle bus: lines released to the pull-ups, clock stands still
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // start or repeated start, never followed by a stop in the same high
  task automatic start_cond();
    #37;
    scl = 1'b0;  // odd offset keeps link edges off the system clock edges
    #300;
    sda_oe = 1'b0;
    #300;
    scl = 1'b1;
    #400;
    sda_oe = 1'b1;
    #400;
  endtask : start_cond
  // stop: sda rises while scl is high
  task automatic stop_cond();
    scl = 1'b0;
    #300;
    sda_oe = 1'b1;
    #300;
    scl = 1'b1;
    #400;
    sda_oe = 1'b0;
    #400;
  endtask : stop_cond
  // one bit per clock, 600 ns low so the device can turn sda round
  task automatic clk_bit(input logic b, output logic s);
    scl = 1'b0;
    #300;
    sda_oe = ~b;
    #300;
    scl = 1'b1;  // 800 ns period, 1.25 MHz, above the 1 MHz ceiling
    s = sda;
    #200;
  endtask : clk_bit
  // msb first, ninth clock carries the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(~mack, s);
  endtask : recv_byte
endmodule : gdi_i2c_master_model

// ==== tb/gdi_i2c_slave_sva.sv ====
`timescale 1ns/10ps
module gdi_i2c_slave_sva #(
  parameter int unsigned POWERUP_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic DAC_UPDATE
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // bus answers exactly one cycle after taking a request, pulse of one cycle
  property p_ack_next; (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus ack missing");
  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
  property p_ack_cause; WB_ACK_O |-> $past(WB_STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("bus ack without strobe");
  // open drain: only the enable moves, the value is always low
  property p_sda_od; SDA_OUT == 1'b0; endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  property p_upd_pulse; DAC_UPDATE |=> !DAC_UPDATE; endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
  // device turns sda round only while the clock is low
  property p_oe_scl_low; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved with scl high");
  property p_ack_hold; (SDA_OE && SCL_IN) |=> (SDA_OE || !SCL_IN); endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda released in clock high");
  property p_rst_quiet; !$past(RSTN) |-> (!SDA_OE && !WB_ACK_O && !DAC_UPDATE); endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  // main scenarios
  c_upd: cover property (DAC_UPDATE);
  c_drive: cover property ($rose(SDA_OE));
  c_ack: cover property (WB_ACK_O);
endmodule : gdi_i2c_slave_sva
bind gdi_i2c_slave gdi_i2c_slave_sva #(.POWERUP_CYCLES(POWERUP_CYCLES)) gdi_i2c_slave_sva_i (
  .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .DAC_UPDATE(DAC_UPDATE));

// ==== tb/tb_gdi_i2c_slave.sv ====
`timescale 1ns/10ps
module tb_gdi_i2c_slave;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        asel = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, scl, m_oe, s_oe, s_out, upd;
  int          checked = 0, num_errors = 0, cycles = 0, upd_cnt = 0;
  wire         sda = ~(s_oe | m_oe);  // pulled-up open-drain wire
  gdi_i2c_slave #(.POWERUP_CYCLES(20)) gdi_i2c_slave_i (
    .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(s_out), .SDA_OE(s_oe), .ADDR_SELECT_PIN(asel), .DAC_UPDATE(upd));
  gdi_i2c_master_model master_i (.scl(scl), .sda_oe(m_oe), .sda(sda));
  // 10 MHz system clock
  always #50 clk = ~clk;
  // cycle budget and update pulse count
  always @(posedge clk) begin
    cycles++;
    if (upd === 1'b1) begin
      upd_cnt++;
    end
    if (cycles == 40000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  // classic single cycle, request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("bus ack", 32'h1, 32'(ack));
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic st(input logic [7:0] p);
    logic [31:0] q;
    wb(1'b0, gdi_pkg::WB_STATUS, 32'h0, q);
    chk("pointer", 32'(p), 32'(q[15:8]));
    chk("busy", 32'h0, 32'(q[gdi_pkg::ST_BUSY_BIT]));
  endtask : st
  task automatic dac(input logic [31:0] i, input logic [9:0] e);
    logic [31:0] q;
    wb(1'b1, gdi_pkg::WB_SEL, i, q);
    wb(1'b0, gdi_pkg::WB_DATA, 32'h0, q);
    chk("dac word", 32'(e), 32'(q[9:0]));
  endtask : dac
  task automatic tx(input logic [7:0] b, input logic e);
    logic a;
    master_i.send_byte(b, a);
    chk("ack", 32'(e), 32'(a));
  endtask : tx
  task automatic hdr(input logic [7:0] p);
    master_i.start_cond();
    tx(8'hE8, 1'b1);
    tx(p, 1'b1);
  endtask : hdr
  task automatic put(input logic [7:0] p, input logic [15:0] w);
    hdr(p);
    tx(w[15:8], 1'b1);
    tx(w[7:0], 1'b1);
    master_i.stop_cond();
  endtask : put
  task automatic rdw(input logic last, input logic [15:0] e);
    logic [7:0] h, l;
    master_i.recv_byte(1'b1, h);
    master_i.recv_byte(~last, l);
    chk("read word", 32'(e), 32'({h, l}));
  endtask : rdw
  task automatic get(input logic [15:0] e);
    master_i.start_cond();
    tx(8'hE9, 1'b1);
    rdw(1'b1, e);
    master_i.stop_cond();
  endtask : get
  task automatic t_reset();
    logic [31:0] q;
    int n;
    chk("sda drive", 32'h0, 32'(s_oe));
    wb(1'b0, gdi_pkg::WB_CTRL, 32'h0, q);
    chk("ctrl", 32'h1, 32'(q[0]));
    n = 0;
    q = 32'h0;
    while (q[gdi_pkg::ST_READY_BIT] !== 1'b1 && n < 40) begin
      wb(1'b0, gdi_pkg::WB_STATUS, 32'h0, q);
      n++;
    end
    chk("ready", 32'h1, 32'(q[gdi_pkg::ST_READY_BIT]));
    st(8'h00);
    wb(1'b1, 4'h2, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask : t_reset
  // every update code, only code 10 copies the buffered words
  task automatic t_update();
    int c0;
    for (int c = 0; c < 4; c++) begin
      c0 = upd_cnt;
      put(8'(c), {c[1:0], 14'h0155});
      chk("update", 32'(c == 2), 32'(upd_cnt - c0));
    end
    dac(32'h2, 10'h155);
    dac(32'h3, 10'h000);
    st(8'h04);
    $display("test update done");
  endtask : t_update
  task automatic t_wrap();
    hdr(8'h2D);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h03, 1'b1);
    tx(8'hFF, 1'b1);
    master_i.stop_cond();
    st(8'hFF);
    get(16'hFFFF);
    get(16'hFFFF);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_index();
    hdr(8'h02);
    master_i.start_cond();
    tx(8'hE9, 1'b1);
    rdw(1'b0, 16'h8155);
    rdw(1'b1, 16'hC155);
    master_i.stop_cond();
    st(8'h04);
    get(16'h0000);
    $display("test indexed read done");
  endtask : t_index
  // select pin levels; each pass sends one matching and one foreign frame,
  // then a disabled port must stay deaf to its own address
  task automatic t_addr();
    logic [31:0] q;
    for (int p = 0; p < 2; p++) begin
      asel <= p[0];
      repeat (4) @(posedge clk);
      for (int a = 1; a >= 0; a--) begin
        master_i.start_cond();
        tx(8'hE8 | 8'(2 * a), 1'(a == p));
        tx((a == p) ? 8'h10 : 8'h20, 1'(a == p));
        master_i.stop_cond();
      end
    end
    asel <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, gdi_pkg::WB_CTRL, 32'h0, q);
    master_i.start_cond();
    tx(8'hE8, 1'b0);
    master_i.stop_cond();
    wb(1'b1, gdi_pkg::WB_CTRL, 32'h1, q);
    st(8'h10);
    $display("test address done");
  endtask : t_addr
  task automatic t_limits();
    put(8'h18, 16'h0100);
    put(8'h12, 16'h0050);
    hdr(8'h12);
    master_i.stop_cond();
    get(16'h0100);
    put(8'h0C, 16'h1234);
    hdr(8'h0C);
    master_i.stop_cond();
    get(16'h0000);
    $display("test limits done");
  endtask : t_limits
  // stop after a lone high byte: frame aborted, half word dropped
  task automatic t_early();
    hdr(8'h05);
    tx(8'h12, 1'b1);
    master_i.stop_cond();
    st(8'h05);
    get(16'h0000);
    $display("test early stop done");
  endtask : t_early
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_update();
    t_wrap();
    t_index();
    t_addr();
    t_limits();
    t_early();
    final_report();
  end
endmodule : tb_gdi_i2c_slave
